// ==== hdl/privilege_mode_segment_protection.sv ====
// How it works
// - five modes, exactly one active
// - start-up and firmware modes unreachable by software
// - exception vectors and forces system mode
// - eight fault sources raise exceptions
// - fixed partitions plus 64 user segments
// - segment holds base, size, enable, rights
// - descriptors fetched from table in memory
// - translation setup only in system mode
// - user accesses and registers are gated
// - mode bit writes can only clear
`default_nettype none
module privilege_mode_segment_protection
  import segment_protection_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // mode control
  input wire logic boot_exit_in,
  input wire logic [1:0] boot_target_in,
  input wire logic test_allowed_in,
  input wire logic fw_exit_in,
  input wire logic mode_wr_in,
  input wire logic mode_wr_sys_in,
  // exception sources
  input wire logic breakpoint_in,
  input wire logic fault_detect_in,
  input wire logic illegal_instr_in,
  input wire logic stack_overflow_in,
  input wire logic syscall_bad_in,
  input wire logic return_from_interrupt_in,
  // memory and register accesses
  input wire logic acc_valid_in,
  input wire logic [1:0] acc_kind_in,
  input wire logic [ADDR_W-1:0] acc_addr_in,
  input wire logic [ADDR_W-1:0] acc_pc_in,
  input wire logic sfr_valid_in,
  input wire logic [SFR_GROUP_W-1:0] sfr_group_in,
  // segment_descriptor_table fetch
  input wire logic [ADDR_W-1:0] tbl_base_in,
  input wire logic tbl_load_in,
  input wire logic tbl_rd_valid_in,
  input wire logic [DESC_W-1:0] tbl_rd_data_in,
  // results
  output cpu_mode_type mode_out,
  output logic acc_grant_out,
  output logic acc_block_out,
  output logic [ADDR_W-1:0] phys_addr_out,
  output logic [1:0] phys_region_out,
  output logic sfr_grant_out,
  output logic exc_out,
  output logic [ADDR_W-1:0] exc_vector_out,
  output logic tbl_busy_out,
  output logic tbl_rd_req_out,
  output logic [ADDR_W-1:0] tbl_rd_addr_out
);

  seg_lookup_if lk ();

  seg_table u_table (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .lk(lk.table_side)
  );

  function automatic logic [1:0] region_of(input logic [ADDR_W-1:0] pa);
    if (pa <= RAM_LAST) return REGION_RAM;
    else if (pa <= ROM_LAST) return REGION_ROM;
    else if (pa <= EEPROM_LAST) return REGION_EEPROM;
    else return REGION_NONE;
  endfunction

  // ==========================================================
  // state
  cpu_mode_type mode_q, mode_d;
  logic exc_q, exc_d;
  logic [ADDR_W-1:0] vec_q, vec_d;
  logic grant_q, grant_d, block_q, block_d, sfr_q, sfr_d;
  logic [ADDR_W-1:0] pa_q, pa_d;
  logic [1:0] region_q, region_d;
  load_state_type ld_q, ld_d;
  logic [SEG_IDX_W-1:0] idx_q, idx_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic req_q, req_d;
  logic [ADDR_W-1:0] raddr_q, raddr_d;

  logic user, busy, perm, viol, collision, sfr_viol, exc_any;
  logic [ADDR_W-1:0] pa_user;

  // ==========================================================
  // access check and translation
  assign lk.look_addr = acc_addr_in;
  assign lk.look_pc = acc_pc_in;
  assign user = (mode_q == MODE_USER);
  assign busy = (ld_q == LD_FETCH);

  always_comb begin
    case (acc_kind_in)
      ACC_READ: perm = lk.can_rd;
      ACC_WRITE: perm = lk.can_wr;
      ACC_EXEC: perm = lk.can_ex;
      default: perm = 1'b0;
    endcase
    pa_user = ADDR_W'(lk.pbase + (acc_addr_in - lk.vbase));
    pa_d = user ? pa_user : acc_addr_in;
    region_d = region_of(pa_d);
    collision = user && acc_valid_in && busy;
    viol = user && acc_valid_in && !busy &&
           (!lk.hit || !perm || region_d == REGION_NONE);
    block_d = acc_valid_in && (viol || collision || region_d == REGION_NONE);
    grant_d = acc_valid_in && !block_d;
    sfr_viol = user && sfr_valid_in && !(lk.pc_hit && lk.pc_sfr[sfr_group_in]);
    sfr_d = sfr_valid_in && !sfr_viol;
  end

  // ==========================================================
  // exceptions and mode
  always_comb begin
    exc_any = 1'b1;
    vec_d = vec_q;
    if (fault_detect_in) vec_d = VEC_FAULT;
    else if (breakpoint_in) vec_d = VEC_BREAKPOINT;
    else if (illegal_instr_in) vec_d = VEC_ILLEGAL;
    else if (stack_overflow_in) vec_d = VEC_STACK;
    else if (syscall_bad_in) vec_d = VEC_SYSCALL;
    else if (return_from_interrupt_in && user) vec_d = VEC_RETURN;
    else if (collision) vec_d = VEC_COLLISION;
    else if (viol || sfr_viol) vec_d = VEC_VIOLATION;
    else exc_any = 1'b0;
    exc_d = exc_any;
    mode_d = mode_q;
    if (exc_any) begin
      mode_d = MODE_SYSTEM;
    end else begin
      case (mode_q)
        MODE_BOOT: begin
          if (boot_exit_in) begin
            if (boot_target_in == BOOT_TO_TEST && test_allowed_in) mode_d = MODE_TEST;
            else if (boot_target_in == BOOT_TO_FIRMWARE) mode_d = MODE_FIRMWARE;
            else if (boot_target_in == BOOT_TO_SYSTEM) mode_d = MODE_SYSTEM;
          end
        end
        MODE_TEST: mode_d = MODE_TEST;
        MODE_FIRMWARE: begin
          if (fw_exit_in) mode_d = MODE_SYSTEM;
        end
        MODE_SYSTEM: begin
          if (mode_wr_in && !mode_wr_sys_in) mode_d = MODE_USER;
        end
        MODE_USER: mode_d = MODE_USER;
        default: mode_d = MODE_BOOT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= MODE_BOOT;
      exc_q <= 1'b0;
      vec_q <= VEC_RESET;
      grant_q <= 1'b0;
      block_q <= 1'b0;
      sfr_q <= 1'b0;
      pa_q <= 16'h0000;
      region_q <= REGION_RAM;
    end else begin
      mode_q <= mode_d;
      exc_q <= exc_d;
      vec_q <= vec_d;
      grant_q <= grant_d;
      block_q <= block_d;
      sfr_q <= sfr_d;
      pa_q <= pa_d;
      region_q <= region_d;
    end
  end

  // ==========================================================
  // descriptor loader
  always_comb begin
    ld_d = ld_q;
    idx_d = idx_q;
    base_d = base_q;
    lk.wr_en = 1'b0;
    lk.wr_idx = idx_q;
    lk.wr_data = tbl_rd_data_in;
    case (ld_q)
      LD_IDLE: begin
        if (tbl_load_in && mode_q == MODE_SYSTEM) begin
          ld_d = LD_FETCH;
          idx_d = 6'h00;
          base_d = tbl_base_in;
        end
      end
      LD_FETCH: begin
        if (tbl_rd_valid_in) begin
          lk.wr_en = 1'b1;
          idx_d = SEG_IDX_W'(idx_q + 6'h01);
          if (idx_q == SEG_LAST) ld_d = LD_IDLE;
        end
      end
      default: ld_d = LD_IDLE;
    endcase
    req_d = (ld_d == LD_FETCH);
    raddr_d = ADDR_W'(base_d + ADDR_W'({idx_d, 3'h0}));
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ld_q <= LD_IDLE;
      idx_q <= 6'h00;
      base_q <= 16'h0000;
      req_q <= 1'b0;
      raddr_q <= 16'h0000;
    end else begin
      ld_q <= ld_d;
      idx_q <= idx_d;
      base_q <= base_d;
      req_q <= req_d;
      raddr_q <= raddr_d;
    end
  end

  // ==========================================================
  // outputs
  assign mode_out = mode_q;
  assign acc_grant_out = grant_q;
  assign acc_block_out = block_q;
  assign phys_addr_out = pa_q;
  assign phys_region_out = region_q;
  assign sfr_grant_out = sfr_q;
  assign exc_out = exc_q;
  assign exc_vector_out = vec_q;
  assign tbl_busy_out = busy;
  assign tbl_rd_req_out = req_q;
  assign tbl_rd_addr_out = raddr_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_mode_legal: assert property (mode_q inside {MODE_BOOT, MODE_TEST, MODE_FIRMWARE,
    MODE_SYSTEM, MODE_USER}) else $error("illegal mode");
  a_boot_once: assert property (mode_q != MODE_BOOT |=> mode_q != MODE_BOOT)
    else $error("start-up mode reentered");
  a_fw_from_boot: assert property (!(mode_q inside {MODE_BOOT, MODE_FIRMWARE})
    |=> mode_q != MODE_FIRMWARE) else $error("firmware mode entered late");
  a_exc_system: assert property (exc_q |-> mode_q == MODE_SYSTEM)
    else $error("exception without system mode");
  a_breakpoint_vec: assert property (breakpoint_in && !fault_detect_in
    |=> exc_q && exc_vector_out == VEC_BREAKPOINT) else $error("bad breakpoint vector");
  a_return_from_interrupt_user: assert property (return_from_interrupt_in && user |=> exc_q)
    else $error("return in user mode not trapped");
  a_load_walk: assert property (busy && tbl_rd_valid_in && idx_q == SEG_LAST
    |=> !tbl_busy_out && !tbl_rd_req_out) else $error("loader overran table");
  a_load_priv: assert property (tbl_load_in && !busy && mode_q != MODE_SYSTEM
    |=> !tbl_busy_out) else $error("load started outside system mode");
  a_sfr_gate: assert property (user && sfr_valid_in && !lk.pc_hit |=> !sfr_grant_out)
    else $error("register access not gated");
  a_no_promote: assert property (user && !exc_any |=> mode_q == MODE_USER)
    else $error("user mode promoted itself");
  a_miss_blocks: assert property (user && acc_valid_in && !busy && !lk.hit
    |=> acc_block_out && !acc_grant_out && exc_q) else $error("miss not blocked");

endmodule
`default_nettype wire

// ==== hdl/segment_protection_pkg.sv ====
`default_nettype none
package segment_protection_pkg;

  // ==========================================================
  // segment table geometry
  localparam int SEG_COUNT = 64;
  localparam int SEG_IDX_W = 6;
  localparam int DESC_W = 64;
  localparam int ADDR_W = 16;
  localparam int SFR_GROUPS = 8;
  localparam int SFR_GROUP_W = 3;
  localparam logic [SEG_IDX_W-1:0] SEG_LAST = 6'h3f;
  localparam int DESC_ADDR_SHIFT = 3;

  // ==========================================================
  // descriptor field layout
  localparam int DESC_VBASE_LSB = 0;
  localparam int DESC_SIZE_LSB = 16;
  localparam int DESC_PBASE_LSB = 32;
  localparam int DESC_EN_BIT = 48;
  localparam int DESC_RD_BIT = 49;
  localparam int DESC_WR_BIT = 50;
  localparam int DESC_EX_BIT = 51;
  localparam int DESC_SFR_LSB = 52;
  localparam logic [DESC_W-1:0] DESC_RESET = 64'h0;

  // ==========================================================
  // fixed physical partitioning
  localparam logic [ADDR_W-1:0] RAM_LAST = 16'h0fff;
  localparam logic [ADDR_W-1:0] ROM_LAST = 16'h7fff;
  localparam logic [ADDR_W-1:0] EEPROM_LAST = 16'hefff;
  localparam logic [1:0] REGION_RAM = 2'h0;
  localparam logic [1:0] REGION_ROM = 2'h1;
  localparam logic [1:0] REGION_EEPROM = 2'h2;
  localparam logic [1:0] REGION_NONE = 2'h3;

  // ==========================================================
  // access kinds and start-up exit targets
  localparam logic [1:0] ACC_READ = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_EXEC = 2'h2;
  localparam logic [1:0] BOOT_TO_TEST = 2'h0;
  localparam logic [1:0] BOOT_TO_FIRMWARE = 2'h1;
  localparam logic [1:0] BOOT_TO_SYSTEM = 2'h2;

  // ==========================================================
  // exception vectors, highest priority first
  localparam logic [ADDR_W-1:0] VEC_FAULT = 16'h0008;
  localparam logic [ADDR_W-1:0] VEC_BREAKPOINT = 16'h0010;
  localparam logic [ADDR_W-1:0] VEC_ILLEGAL = 16'h0018;
  localparam logic [ADDR_W-1:0] VEC_STACK = 16'h0020;
  localparam logic [ADDR_W-1:0] VEC_SYSCALL = 16'h0028;
  localparam logic [ADDR_W-1:0] VEC_RETURN = 16'h0030;
  localparam logic [ADDR_W-1:0] VEC_COLLISION = 16'h0038;
  localparam logic [ADDR_W-1:0] VEC_VIOLATION = 16'h0040;
  localparam logic [ADDR_W-1:0] VEC_RESET = 16'h0000;

  typedef enum logic [2:0] {
    MODE_BOOT, MODE_TEST, MODE_FIRMWARE, MODE_SYSTEM, MODE_USER
  } cpu_mode_type;

  typedef enum logic [0:0] {LD_IDLE, LD_FETCH} load_state_type;

endpackage
`default_nettype wire

// ==== hdl/seg_lookup_if.sv ====
`default_nettype none
interface seg_lookup_if;
  import segment_protection_pkg::*;
  logic wr_en;
  logic [SEG_IDX_W-1:0] wr_idx;
  logic [DESC_W-1:0] wr_data;
  logic [ADDR_W-1:0] look_addr;
  logic [ADDR_W-1:0] look_pc;
  logic hit;
  logic [ADDR_W-1:0] vbase;
  logic [ADDR_W-1:0] pbase;
  logic can_rd;
  logic can_wr;
  logic can_ex;
  logic pc_hit;
  logic [SFR_GROUPS-1:0] pc_sfr;

  modport owner_side(
    output wr_en, wr_idx, wr_data, look_addr, look_pc,
    input hit, vbase, pbase, can_rd, can_wr, can_ex, pc_hit, pc_sfr
  );
  modport table_side(
    input wr_en, wr_idx, wr_data, look_addr, look_pc,
    output hit, vbase, pbase, can_rd, can_wr, can_ex, pc_hit, pc_sfr
  );
endinterface
`default_nettype wire

// ==== hdl/seg_table.sv ====
`default_nettype none
module seg_table
  import segment_protection_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // table port
  seg_lookup_if.table_side lk
);

  logic [DESC_W-1:0] desc_q [SEG_COUNT];
  logic [DESC_W-1:0] desc_d [SEG_COUNT];

  // ==========================================================
  // segment match
  function automatic logic seg_contains(input logic [DESC_W-1:0] d,
                                        input logic [ADDR_W-1:0] a);
    logic [ADDR_W:0] off;
    off = {1'b0, a} - {1'b0, d[DESC_VBASE_LSB +: ADDR_W]};
    return d[DESC_EN_BIT] && (a >= d[DESC_VBASE_LSB +: ADDR_W]) &&
           (off < {1'b0, d[DESC_SIZE_LSB +: ADDR_W]});
  endfunction

  // ==========================================================
  // descriptor storage
  always_comb begin
    desc_d = desc_q;
    if (lk.wr_en) begin
      desc_d[lk.wr_idx] = lk.wr_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        desc_q[i] <= DESC_RESET;
      end
    end else begin
      desc_q <= desc_d;
    end
  end

  // ==========================================================
  // lookup, lowest index wins
  always_comb begin
    logic [DESC_W-1:0] dsel;
    logic [DESC_W-1:0] psel;
    dsel = DESC_RESET;
    psel = DESC_RESET;
    lk.hit = 1'b0;
    lk.pc_hit = 1'b0;
    for (int i = SEG_COUNT - 1; i >= 0; i--) begin
      if (seg_contains(desc_q[i], lk.look_addr)) begin
        lk.hit = 1'b1;
        dsel = desc_q[i];
      end
      if (seg_contains(desc_q[i], lk.look_pc)) begin
        lk.pc_hit = 1'b1;
        psel = desc_q[i];
      end
    end
    lk.vbase = dsel[DESC_VBASE_LSB +: ADDR_W];
    lk.pbase = dsel[DESC_PBASE_LSB +: ADDR_W];
    lk.can_rd = dsel[DESC_RD_BIT];
    lk.can_wr = dsel[DESC_WR_BIT];
    lk.can_ex = dsel[DESC_EX_BIT];
    lk.pc_sfr = psel[DESC_SFR_LSB +: SFR_GROUPS];
  end

endmodule
`default_nettype wire

// ==== verification/seg_table_mem_model.sv ====
`default_nettype none
module seg_table_mem_model
  import segment_protection_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // descriptor fetch
  input wire logic rd_req_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic [1:0] wait_in,
  output logic rd_valid_out,
  output logic [DESC_W-1:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // table image, found at whatever base the loader points to
  logic [DESC_W-1:0] mem [SEG_COUNT];
  logic [1:0] cnt_q;
  logic [ADDR_W-1:0] off;
  assign off = (rd_addr_in - base_in) >> DESC_ADDR_SHIFT;
  // data line toggles whenever no word is offered
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
      cnt_q <= '0;
    end else if (rd_valid_out || !rd_req_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= ~rd_data_out;
      cnt_q <= '0;
    end else if (cnt_q == wait_in) begin
      rd_valid_out <= 1'b1;
      rd_data_out <= mem[off[SEG_IDX_W-1:0]];
    end else begin
      cnt_q <= cnt_q + 2'h1;
      rd_data_out <= ~rd_data_out;
    end
  end
endmodule
`default_nettype wire

// ==== verification/privilege_mode_segment_protection_tb_top.sv ====
`default_nettype none
module privilege_mode_segment_protection_tb_top
  import segment_protection_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic sys_clk_in = 1'b0;
  logic rstn_in, boot_exit_in, test_allowed_in, fw_exit_in, mode_wr_in, mode_wr_sys_in;
  logic breakpoint_in, fault_detect_in, illegal_instr_in, stack_overflow_in, syscall_bad_in;
  logic return_from_interrupt_in, acc_valid_in, sfr_valid_in, tbl_load_in, tbl_rd_valid_in;
  logic [1:0] boot_target_in, acc_kind_in, phys_region_out, wait_sel;
  logic [SFR_GROUP_W-1:0] sfr_group_in;
  logic [ADDR_W-1:0] acc_addr_in, acc_pc_in, tbl_base_in, phys_addr_out, exc_vector_out;
  logic [ADDR_W-1:0] tbl_rd_addr_out;
  logic [DESC_W-1:0] tbl_rd_data_in;
  cpu_mode_type mode_out;
  logic acc_grant_out, acc_block_out, sfr_grant_out, exc_out, tbl_busy_out, tbl_rd_req_out;
  int n_fail = 0;
  int total_checks = 0;
  int n_words = 0;

  always #2.5 sys_clk_in = ~sys_clk_in;

  privilege_mode_segment_protection dut_u (
    .sys_clk_in, .rstn_in, .boot_exit_in, .boot_target_in, .test_allowed_in, .fw_exit_in,
    .mode_wr_in, .mode_wr_sys_in, .breakpoint_in, .fault_detect_in, .illegal_instr_in,
    .stack_overflow_in, .syscall_bad_in, .return_from_interrupt_in, .acc_valid_in,
    .acc_kind_in, .acc_addr_in, .acc_pc_in, .sfr_valid_in, .sfr_group_in, .tbl_base_in,
    .tbl_load_in, .tbl_rd_valid_in, .tbl_rd_data_in, .mode_out, .acc_grant_out,
    .acc_block_out, .phys_addr_out, .phys_region_out, .sfr_grant_out, .exc_out,
    .exc_vector_out, .tbl_busy_out, .tbl_rd_req_out, .tbl_rd_addr_out
  );
  seg_table_mem_model mem_u (
    .sys_clk_in, .rstn_in, .rd_req_in(tbl_rd_req_out), .rd_addr_in(tbl_rd_addr_out),
    .base_in(tbl_base_in), .wait_in(wait_sel), .rd_valid_out(tbl_rd_valid_in),
    .rd_data_out(tbl_rd_data_in)
  );

  // counts descriptor words handed over
  always @(posedge sys_clk_in) begin
    if (tbl_rd_req_out === 1'b1 && tbl_rd_valid_in === 1'b1) n_words++;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [DESC_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  task automatic pulse(ref logic s);
    step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic src(input logic [5:0] v);
    {fault_detect_in, breakpoint_in, illegal_instr_in, stack_overflow_in, syscall_bad_in,
     return_from_interrupt_in} = v;
  endtask

  task automatic do_reset;
    rstn_in = 1'b0;
    {boot_exit_in, test_allowed_in, fw_exit_in, mode_wr_in, mode_wr_sys_in} = '0;
    {acc_valid_in, sfr_valid_in, tbl_load_in, boot_target_in, acc_kind_in} = '0;
    {sfr_group_in, acc_addr_in, acc_pc_in, tbl_base_in, wait_sel} = '0;
    src(6'h00);
    step(12);
    rstn_in = 1'b1;
    step(1);
  endtask

  task automatic to_user;
    mode_wr_sys_in = 1'b0;
    pulse(mode_wr_in);
  endtask

  task automatic acc(input logic [1:0] k, input logic [ADDR_W-1:0] a, p);
    acc_kind_in = k;
    acc_addr_in = a;
    acc_pc_in = p;
    pulse(acc_valid_in);
  endtask

  task automatic sfr(input logic [SFR_GROUP_W-1:0] g, input logic [ADDR_W-1:0] p);
    sfr_group_in = g;
    acc_pc_in = p;
    pulse(sfr_valid_in);
  endtask

  function automatic logic [DESC_W-1:0] desc(input logic [15:0] vb, sz, pb,
                                             input logic [3:0] xwre, input logic [7:0] grp);
    desc = '0;
    desc[DESC_VBASE_LSB +: 16] = vb;
    desc[DESC_SIZE_LSB +: 16] = sz;
    desc[DESC_PBASE_LSB +: 16] = pb;
    desc[DESC_EN_BIT +: 4] = xwre;
    desc[DESC_SFR_LSB +: 8] = grp;
  endfunction

  task automatic load_tbl(input logic [ADDR_W-1:0] b, input logic [1:0] w);
    tbl_base_in = b;
    wait_sel = w;
    pulse(tbl_load_in);
    chk("busy", tbl_busy_out, 1'b1);
    chk("req", tbl_rd_req_out, 1'b1);
    chk("rd_addr", tbl_rd_addr_out, b);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 2000 && tbl_busy_out !== 1'b0; i++) step(1);
    chk("busy", tbl_busy_out, 1'b0);
  endtask

  task automatic ucase(input logic [1:0] k, input logic [ADDR_W-1:0] a, input logic g,
                       input logic [ADDR_W-1:0] ph, input logic [1:0] rg);
    acc(k, a, 16'h1000);
    chk("grant", acc_grant_out, g);
    chk("block", acc_block_out, !g);
    chk("exc", exc_out, !g);
    if (g) begin
      chk("phys", phys_addr_out, ph);
      chk("region", phys_region_out, rg);
    end else begin
      chk("vector", exc_vector_out, VEC_VIOLATION);
    end
    to_user;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_modes;
    do_reset;
    chk("mode", mode_out, MODE_BOOT);
    boot_target_in = BOOT_TO_TEST;
    pulse(boot_exit_in);
    chk("mode", mode_out, MODE_BOOT);
    test_allowed_in = 1'b1;
    pulse(boot_exit_in);
    chk("mode", mode_out, MODE_TEST);
    to_user;
    chk("mode", mode_out, MODE_TEST);
    pulse(breakpoint_in);
    chk("mode", mode_out, MODE_SYSTEM);
    do_reset;
    boot_target_in = 2'h3;
    pulse(boot_exit_in);
    chk("mode", mode_out, MODE_BOOT);
    boot_target_in = BOOT_TO_SYSTEM;
    pulse(boot_exit_in);
    chk("mode", mode_out, MODE_SYSTEM);
    do_reset;
    boot_target_in = BOOT_TO_FIRMWARE;
    pulse(boot_exit_in);
    chk("mode", mode_out, MODE_FIRMWARE);
    to_user;
    chk("mode", mode_out, MODE_FIRMWARE);
    pulse(fw_exit_in);
    chk("mode", mode_out, MODE_SYSTEM);
    mode_wr_sys_in = 1'b1;
    pulse(mode_wr_in);
    chk("mode", mode_out, MODE_SYSTEM);
    to_user;
    chk("mode", mode_out, MODE_USER);
    mode_wr_sys_in = 1'b1;
    pulse(mode_wr_in);
    pulse(boot_exit_in);
    pulse(fw_exit_in);
    chk("mode", mode_out, MODE_USER);
    $display("test modes done");
  endtask

  task automatic t_exceptions;
    logic [ADDR_W-1:0] vec [6] = '{VEC_FAULT, VEC_BREAKPOINT, VEC_ILLEGAL, VEC_STACK,
                                    VEC_SYSCALL, VEC_RETURN};
    for (int i = 0; i < 6; i++) begin
      src(6'h20 >> i);
      step(1);
      src(6'h00);
      chk("exc", exc_out, 1'b1);
      chk("vector", exc_vector_out, vec[i]);
      chk("mode", mode_out, MODE_SYSTEM);
      to_user;
    end
    src(6'h30);
    step(1);
    src(6'h00);
    chk("vector", exc_vector_out, VEC_FAULT);
    pulse(return_from_interrupt_in);
    chk("exc", exc_out, 1'b0);
    to_user;
    $display("test exceptions done");
  endtask

  task automatic t_table;
    for (int i = 0; i < SEG_COUNT; i++) mem_u.mem[i] = '0;
    mem_u.mem[0] = desc(16'h1000, 16'h0100, 16'h0200, 4'hb, 8'h04);
    mem_u.mem[1] = desc(16'h1000, 16'h0200, 16'h4000, 4'h7, 8'h00);
    mem_u.mem[2] = desc(16'h3000, 16'h0100, 16'h0000, 4'he, 8'hff);
    pulse(tbl_load_in);
    chk("busy", tbl_busy_out, 1'b0);
    pulse(breakpoint_in);
    n_words = 0;
    load_tbl(16'h2000, 2'h2);
    to_user;
    acc(ACC_READ, 16'h1010, 16'h1000);
    chk("block", acc_block_out, 1'b1);
    chk("vector", exc_vector_out, VEC_COLLISION);
    wait_idle;
    load_tbl(16'h5008, 2'h0);
    wait_idle;
    chk("words", n_words, 128);
    to_user;
    $display("test table done");
  endtask

  task automatic t_user;
    ucase(ACC_READ, 16'h1010, 1'b1, 16'h0210, REGION_RAM);
    ucase(ACC_EXEC, 16'h10ff, 1'b1, 16'h02ff, REGION_RAM);
    ucase(ACC_WRITE, 16'h1010, 1'b0, 16'h0000, REGION_RAM);
    ucase(ACC_WRITE, 16'h11ff, 1'b1, 16'h41ff, REGION_ROM);
    ucase(ACC_EXEC, 16'h1150, 1'b0, 16'h0000, REGION_RAM);
    ucase(ACC_READ, 16'h1200, 1'b0, 16'h0000, REGION_RAM);
    ucase(ACC_READ, 16'h3010, 1'b0, 16'h0000, REGION_RAM);
    ucase(ACC_READ, 16'h0fff, 1'b0, 16'h0000, REGION_RAM);
    sfr(3'h2, 16'h1000);
    chk("sfr_grant", sfr_grant_out, 1'b1);
    sfr(3'h3, 16'h1000);
    chk("sfr_grant", sfr_grant_out, 1'b0);
    chk("vector", exc_vector_out, VEC_VIOLATION);
    to_user;
    sfr(3'h0, 16'h2000);
    chk("sfr_grant", sfr_grant_out, 1'b0);
    chk("exc", exc_out, 1'b1);
    $display("test user access done");
  endtask

  task automatic t_system;
    pulse(breakpoint_in);
    acc(ACC_WRITE, 16'h0800, 16'h3000);
    chk("grant", acc_grant_out, 1'b1);
    chk("phys", phys_addr_out, 16'h0800);
    acc(ACC_READ, 16'h9000, 16'h3000);
    chk("region", phys_region_out, REGION_EEPROM);
    acc(ACC_READ, 16'hf000, 16'h3000);
    chk("block", acc_block_out, 1'b1);
    chk("exc", exc_out, 1'b0);
    sfr(3'h3, 16'h3000);
    chk("sfr_grant", sfr_grant_out, 1'b1);
    $display("test system access done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    t_modes;
    t_exceptions;
    t_table;
    t_user;
    t_system;
    final_report;
  end

  initial begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
